// file: logic/link_control_and_ecc_tx_buffer.sv
// link status and control, link label and message transmit buffer registers
// assumes a synchronous byte register port and receive-side logic on clk;
// loss of signal levels come from pins and are synchronised here
`default_nettype none
`include "link_ctl_map.svh"

module link_control_and_ecc_tx_buffer #(
  parameter int NUM_MSG_BYTES = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // processor register port
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire link_ctl_pkg::reg_byte_t cpu_wdata,
  output link_ctl_pkg::reg_byte_t cpu_rdata,
  // receive side status
  input wire logic port_a_signal_loss,
  input wire logic port_b_signal_loss,
  input wire logic port_a_remote_lock,
  input wire logic port_b_remote_lock,
  input wire logic switch_finished,
  input wire logic port_a_rx_buffer_full,
  input wire logic port_b_rx_buffer_full,
  // received message signalling
  input wire logic port_a_signal_select,
  input wire logic port_b_signal_select,
  input wire logic port_a_msg_ack_signal_a,
  input wire logic port_a_msg_ack_signal_b,
  input wire logic port_b_msg_ack_signal_a,
  input wire logic port_b_msg_ack_signal_b,
  // transmit and receive link control
  output logic active_port_select,
  output logic port_switch_done,
  output logic scrambler_enable,
  output logic coset_enable,
  output logic send_scrambler_seq,
  output logic hold_traffic,
  output logic [7:0] link_label_byte,
  output logic port_a_remote_alarm_clear,
  output logic port_b_remote_alarm_clear,
  // message channel
  output logic msg_tx_active,
  output logic msg_tx_start,
  output logic [8*NUM_MSG_BYTES-1:0] msg_data_bytes,
  output logic port_a_msg_rx_enable,
  output logic port_b_msg_rx_enable,
  output logic port_a_rx_buffer_flag,
  output logic port_b_rx_buffer_flag,
  // interrupt request
  output logic irq
);
  import link_ctl_pkg::*;

  localparam logic [7:0] LSC_WR_MASK = 8'hfb;

  reg_byte_t lsc_ff;
  reg_byte_t label_ff;
  logic [3:0] alarm_ie_ff;
  logic [2:0] loss_flag_ff;
  msg_state_e msg_state_ff;
  logic acked_a_ff;
  logic acked_b_ff;
  logic start_ff;
  logic rxbuf_a_ff;
  logic rxbuf_b_ff;
  logic loss_a_prev_ff;
  logic loss_b_prev_ff;
  reg_byte_t rdata_ff;
  reg_byte_t msg_data_ff [NUM_MSG_BYTES];

  logic [1:0] loss_sync;
  logic loss_a;
  logic loss_b;
  logic en_a;
  logic en_b;
  logic ack_a;
  logic ack_b;
  logic lock_active;
  logic wr_lsc;
  logic wr_send;
  logic rd_alarms;
  logic msg_done;
  logic [7:0] data_idx;
  reg_byte_t nxt_rdata;
  reg_byte_t alarms;

  initial
  begin
    if (NUM_MSG_BYTES != 8)
    begin
      $error("message buffer is mapped for exactly 8 bytes");
    end
  end

  sync2 #(
    .WIDTH(2)
  ) u_loss_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({port_a_signal_loss, port_b_signal_loss}),
    .sync_out(loss_sync)
  );

  assign loss_a = loss_sync[1];
  assign loss_b = loss_sync[0];

  // decode
  assign wr_lsc = cpu_wr && (cpu_addr == `LINK_STATUS_CONTROL_OFS);
  assign wr_send = cpu_wr && (cpu_addr == `MSG_SEND_OFS);
  assign rd_alarms = cpu_rd && (cpu_addr == `MSG_BUFFER_AND_RX_ALARMS_OFS);
  assign data_idx = 8'(`MSG_DATA_LAST_OFS - cpu_addr);

  assign en_a = lsc_ff[`LSC_MSG_PORT_A_ENABLE];
  assign en_b = lsc_ff[`LSC_MSG_PORT_B_ENABLE];

  // acks picked by each port's select, ignored while the port is off
  assign ack_a = en_a && (port_a_signal_select ? port_a_msg_ack_signal_b
                                               : port_a_msg_ack_signal_a);
  assign ack_b = en_b && (port_b_signal_select ? port_b_msg_ack_signal_b
                                               : port_b_msg_ack_signal_a);
  // every enabled far end must have acknowledged
  assign msg_done = (msg_state_ff == MSG_SENDING)
                    && (!en_a || acked_a_ff || ack_a)
                    && (!en_b || acked_b_ff || ack_b);

  // link status and control register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lsc_ff <= `LINK_STATUS_CONTROL_RST;
    end
    else
    begin
      if (wr_lsc)
      begin
        lsc_ff <= (cpu_wdata & LSC_WR_MASK) | (lsc_ff & ~LSC_WR_MASK);
        if (cpu_wdata[`LSC_ACTIVE_PORT_SELECT] != lsc_ff[`LSC_ACTIVE_PORT_SELECT])
        begin
          lsc_ff[`LSC_PORT_SWITCH_DONE] <= 1'b0;
        end
      end
      // completion wins over a clear in the same cycle
      if (switch_finished)
      begin
        lsc_ff[`LSC_PORT_SWITCH_DONE] <= 1'b1;
      end
    end
  end

  // label and interrupt enables
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      label_ff <= `TX_LINK_TRACE_LABEL_RST;
      alarm_ie_ff <= 4'(`MSG_ALARM_ENABLES_RST);
    end
    else if (cpu_wr && (cpu_addr == `TX_LINK_TRACE_LABEL_OFS))
    begin
      label_ff <= cpu_wdata;
    end
    else if (cpu_wr && (cpu_addr == `MSG_ALARM_ENABLES_OFS))
    begin
      alarm_ie_ff <= cpu_wdata[3:0];
    end
  end

  // message buffer state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      msg_state_ff <= MSG_READY;
      acked_a_ff <= 1'b0;
      acked_b_ff <= 1'b0;
      start_ff <= 1'b0;
    end
    else
    begin
      start_ff <= 1'b0;
      if (!en_a && !en_b)
      begin
        msg_state_ff <= MSG_OFF;
        acked_a_ff <= 1'b0;
        acked_b_ff <= 1'b0;
      end
      else
      begin
        case (msg_state_ff)
          MSG_OFF:
          begin
            msg_state_ff <= MSG_READY;
          end
          MSG_READY:
          begin
            if (wr_send && cpu_wdata[`SEND_MSG_SEND])
            begin
              msg_state_ff <= MSG_SENDING;
              acked_a_ff <= 1'b0;
              acked_b_ff <= 1'b0;
              start_ff <= 1'b1;
            end
          end
          MSG_SENDING:
          begin
            if (msg_done || (wr_send && !cpu_wdata[`SEND_MSG_SEND]))
            begin
              msg_state_ff <= MSG_READY;
            end
            if (ack_a)
            begin
              acked_a_ff <= 1'b1;
            end
            if (ack_b)
            begin
              acked_b_ff <= 1'b1;
            end
          end
          default:
          begin
            msg_state_ff <= MSG_OFF;
          end
        endcase
      end
    end
  end

  // message data bytes, writable only while the buffer is ready
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_MSG_BYTES; i++)
      begin
        msg_data_ff[i] <= `MSG_DATA_RST;
      end
    end
    else if (cpu_wr && (cpu_addr >= `MSG_DATA_FIRST_OFS) && (cpu_addr <= `MSG_DATA_LAST_OFS)
             && (msg_state_ff == MSG_READY))
    begin
      msg_data_ff[data_idx[2:0]] <= cpu_wdata;
    end
  end

  // loss of signal flags; a new event wins over clear on read
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loss_flag_ff <= '0;
      loss_a_prev_ff <= 1'b0;
      loss_b_prev_ff <= 1'b0;
    end
    else
    begin
      loss_a_prev_ff <= loss_a;
      loss_b_prev_ff <= loss_b;
      loss_flag_ff <= (rd_alarms ? 3'b000 : loss_flag_ff)
                      | {(loss_a != loss_a_prev_ff) || (loss_b != loss_b_prev_ff),
                         loss_a, loss_b};
    end
  end

  // receive buffer flags held clear for a disabled port
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxbuf_a_ff <= 1'b0;
      rxbuf_b_ff <= 1'b0;
    end
    else
    begin
      rxbuf_a_ff <= en_a && port_a_rx_buffer_full;
      rxbuf_b_ff <= en_b && port_b_rx_buffer_full;
    end
  end

  // read data; the ready bit is status only and survives reads
  assign alarms = {4'h0, loss_flag_ff, msg_state_ff == MSG_READY};

  always_comb
  begin
    nxt_rdata = 8'h00;
    if (cpu_addr == `LINK_STATUS_CONTROL_OFS)
    begin
      nxt_rdata = lsc_ff;
    end
    else if (cpu_addr == `TX_LINK_TRACE_LABEL_OFS)
    begin
      nxt_rdata = label_ff;
    end
    else if (cpu_addr == `MSG_BUFFER_AND_RX_ALARMS_OFS)
    begin
      nxt_rdata = alarms;
    end
    else if (cpu_addr == `MSG_ALARM_ENABLES_OFS)
    begin
      nxt_rdata = {4'h0, alarm_ie_ff};
    end
    else if (cpu_addr == `MSG_SEND_OFS)
    begin
      nxt_rdata = {7'h00, msg_state_ff == MSG_SENDING};
    end
    else if ((cpu_addr >= `MSG_DATA_FIRST_OFS) && (cpu_addr <= `MSG_DATA_LAST_OFS))
    begin
      nxt_rdata = msg_data_ff[data_idx[2:0]];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_ff <= 8'h00;
    end
    else if (cpu_rd)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // link control outputs
  assign lock_active = lsc_ff[`LSC_ACTIVE_PORT_SELECT] ? port_b_remote_lock
                                                        : port_a_remote_lock;
  assign hold_traffic = !lsc_ff[`LSC_REMOTE_LOCK_OVERRIDE] && !lock_active;
  assign send_scrambler_seq = hold_traffic || lsc_ff[`LSC_FORCE_SCRAMBLER_SEQ];
  assign scrambler_enable = !lsc_ff[`LSC_SCRAMBLER_DISABLE];
  assign coset_enable = lsc_ff[`LSC_COSET_ENABLE];
  assign active_port_select = lsc_ff[`LSC_ACTIVE_PORT_SELECT];
  assign port_switch_done = lsc_ff[`LSC_PORT_SWITCH_DONE];
  assign link_label_byte = label_ff;
  assign port_a_remote_alarm_clear = loss_a;
  assign port_b_remote_alarm_clear = loss_b;

  assign msg_tx_active = (msg_state_ff == MSG_SENDING);
  assign msg_tx_start = start_ff;
  assign port_a_msg_rx_enable = en_a;
  assign port_b_msg_rx_enable = en_b;
  assign port_a_rx_buffer_flag = rxbuf_a_ff;
  assign port_b_rx_buffer_flag = rxbuf_b_ff;
  assign cpu_rdata = rdata_ff;
  assign irq = |(alarms[3:0] & alarm_ie_ff);

  genvar g;
  generate
    for (g = 0; g < NUM_MSG_BYTES; g++)
    begin : g_data_out
      assign msg_data_bytes[8*g +: 8] = msg_data_ff[g];
    end
  endgenerate

  chk_lock_idle: assert property (@(posedge clk) disable iff (!resetn)
    (!lsc_ff[`LSC_REMOTE_LOCK_OVERRIDE]
     && !(active_port_select ? port_b_remote_lock : port_a_remote_lock))
    |-> send_scrambler_seq && hold_traffic)
    else $error("unlocked remote without scrambler idles");
  chk_override_traffic: assert property (@(posedge clk) disable iff (!resetn)
    lsc_ff[`LSC_REMOTE_LOCK_OVERRIDE] |-> !hold_traffic)
    else $error("traffic held despite override");
  chk_force_seq: assert property (@(posedge clk) disable iff (!resetn)
    lsc_ff[`LSC_FORCE_SCRAMBLER_SEQ] |-> send_scrambler_seq)
    else $error("forced scrambler sequence not sent");
  chk_send_locks: assert property (@(posedge clk) disable iff (!resetn)
    (wr_send && cpu_wdata[0] && msg_state_ff == MSG_READY && (en_a || en_b))
    |=> msg_tx_active && !alarms[0] && msg_tx_start)
    else $error("send did not take the buffer");
  chk_start_gate: assert property (@(posedge clk) disable iff (!resetn)
    (wr_send && cpu_wdata[`SEND_MSG_SEND] && (msg_state_ff != MSG_READY)) |=> !msg_tx_start)
    else $error("send started without a ready buffer");
  chk_data_stable: assert property (@(posedge clk) disable iff (!resetn)
    (msg_state_ff != MSG_READY) |=> $stable(msg_data_bytes))
    else $error("message data changed while buffer not ready");
  chk_single_ack: assert property (@(posedge clk) disable iff (!resetn)
    (msg_tx_active && en_a && !en_b && ack_a) |=> alarms[0] && !msg_tx_active)
    else $error("port a ack did not free buffer");
  chk_both_acks: assert property (@(posedge clk) disable iff (!resetn)
    (msg_tx_active && en_a && en_b && !acked_b_ff && !ack_b && !wr_send) |=> !alarms[0])
    else $error("buffer freed before both acks");
  chk_off_clear: assert property (@(posedge clk) disable iff (!resetn)
    (!en_a && !en_b) |=> !alarms[0] && !msg_tx_active && !rxbuf_a_ff && !rxbuf_b_ff)
    else $error("channel active with both ports off");
  chk_switch_clear: assert property (@(posedge clk) disable iff (!resetn)
    (wr_lsc && (cpu_wdata[1] != lsc_ff[1]) && !switch_finished) |=> !port_switch_done)
    else $error("port change kept switch done");
  chk_loss_change: assert property (@(posedge clk) disable iff (!resetn)
    ($changed(loss_a) || $changed(loss_b)) |=> loss_flag_ff[2])
    else $error("loss change flag not set");
  chk_read_ready: assert property (@(posedge clk) disable iff (!resetn)
    (rd_alarms && msg_state_ff == MSG_READY && !wr_send && (en_a || en_b)) |=> alarms[0])
    else $error("alarm read cleared ready");

endmodule // link_control_and_ecc_tx_buffer

`default_nettype wire

// file: logic/link_ctl_map.svh
// register offsets, field positions and reset values of the link control block
// assumes byte-wide processor registers at the printed byte offsets
`ifndef LINK_CTL_MAP_SVH
`define LINK_CTL_MAP_SVH

// register offsets
`define LINK_STATUS_CONTROL_OFS 8'h08
`define TX_LINK_TRACE_LABEL_OFS 8'h09
`define MSG_BUFFER_AND_RX_ALARMS_OFS 8'h0a
`define MSG_ALARM_ENABLES_OFS 8'h0b
`define MSG_SEND_OFS 8'h0c
`define MSG_DATA_FIRST_OFS 8'h0d
`define MSG_DATA_LAST_OFS 8'h14

// link status and control fields
`define LSC_REMOTE_LOCK_OVERRIDE 7
`define LSC_SCRAMBLER_DISABLE 6
`define LSC_COSET_ENABLE 5
`define LSC_MSG_PORT_A_ENABLE 4
`define LSC_MSG_PORT_B_ENABLE 3
`define LSC_PORT_SWITCH_DONE 2
`define LSC_ACTIVE_PORT_SELECT 1
`define LSC_FORCE_SCRAMBLER_SEQ 0

// buffer and alarm fields, same layout in the enable register
`define ALM_SIGNAL_LOSS_CHANGED 3
`define ALM_PORT_A_SIGNAL_LOSS 2
`define ALM_PORT_B_SIGNAL_LOSS 1
`define ALM_MSG_BUFFER_READY 0

// send register field
`define SEND_MSG_SEND 0

// reset values
`define LINK_STATUS_CONTROL_RST 8'h34
`define TX_LINK_TRACE_LABEL_RST 8'h00
`define MSG_BUFFER_AND_RX_ALARMS_RST 8'h01
`define MSG_ALARM_ENABLES_RST 8'h00
`define MSG_DATA_RST 8'h00

`endif

// file: logic/link_ctl_pkg.sv
// types shared by the link control block
// assumes nothing of its surroundings
`default_nettype none

package link_ctl_pkg;

  // message transmit buffer states, one-hot
  typedef enum logic [2:0]
  {
    MSG_OFF = 3'b001,
    MSG_READY = 3'b010,
    MSG_SENDING = 3'b100
  } msg_state_e;

  typedef logic [7:0] reg_byte_t;

endpackage

`default_nettype wire

// file: logic/sync2.sv
// two flip-flop synchroniser for levels arriving from outside the clock domain
// assumes each bit is an independent slow level
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("sync2 needs WIDTH of at least 1");
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // sync2

`default_nettype wire

// file: test/far_end_model.sv
// far end message receivers of the remote bridge, answering each sent message
// assumes the near end start pulse is a one-cycle pulse on clk
`default_nettype none

module far_end_model
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // message start from the near end
  input wire logic msg_tx_start,
  // reply delay per port and the line each port signals on
  input wire logic [7:0] port_a_delay,
  input wire logic [7:0] port_b_delay,
  input wire logic port_a_use_b,
  input wire logic port_b_use_b,
  // acknowledge lines
  output logic port_a_msg_ack_signal_a,
  output logic port_a_msg_ack_signal_b,
  output logic port_b_msg_ack_signal_a,
  output logic port_b_msg_ack_signal_b
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_a;
  logic [7:0] cnt_b;
  logic pulse_a;
  logic pulse_b;

  // one pulse per received message, on the line the far end chose
  assign port_a_msg_ack_signal_a = pulse_a & ~port_a_use_b;
  assign port_a_msg_ack_signal_b = pulse_a & port_a_use_b;
  assign port_b_msg_ack_signal_a = pulse_b & ~port_b_use_b;
  assign port_b_msg_ack_signal_b = pulse_b & port_b_use_b;

  // counts on the falling edge so the pulse is steady at the rising one
  always @(negedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_a <= 8'h00;
      cnt_b <= 8'h00;
      pulse_a <= 1'b0;
      pulse_b <= 1'b0;
    end
    else
    begin
      pulse_a <= (cnt_a == 8'h01);
      pulse_b <= (cnt_b == 8'h01);
      if (msg_tx_start)
      begin
        cnt_a <= port_a_delay;
        cnt_b <= port_b_delay;
      end
      else
      begin
        if (cnt_a != 8'h00)
          cnt_a <= cnt_a - 8'h01;
        if (cnt_b != 8'h00)
          cnt_b <= cnt_b - 8'h01;
      end
    end
  end
endmodule // far_end_model

`default_nettype wire

// file: test/link_control_and_ecc_tx_buffer_tb.sv
// self-checking bench for the link control and message transmit buffer registers
// assumes the register map header and the far end model beside this file
`default_nettype none
`include "link_ctl_map.svh"

module link_control_and_ecc_tx_buffer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import link_ctl_pkg::*;

  localparam logic [7:0] a_lsc = `LINK_STATUS_CONTROL_OFS;
  localparam logic [7:0] a_lbl = `TX_LINK_TRACE_LABEL_OFS;
  localparam logic [7:0] a_alm = `MSG_BUFFER_AND_RX_ALARMS_OFS;
  localparam logic [7:0] a_ien = `MSG_ALARM_ENABLES_OFS;
  localparam logic [7:0] a_snd = `MSG_SEND_OFS;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  reg_byte_t cpu_wdata = 8'h00;
  reg_byte_t cpu_rdata;
  logic loss_a = 1'b0, loss_b = 1'b0, lock_a = 1'b1, lock_b = 1'b1, sw_fin = 1'b0;
  logic full_a = 1'b1, full_b = 1'b1, sel_a = 1'b0, sel_b = 1'b0;
  logic far_a_b = 1'b0, far_b_b = 1'b0;
  logic [7:0] dly_a = 8'h05, dly_b = 8'h05;
  logic ack_aa, ack_ab, ack_ba, ack_bb;
  logic act_sel, sw_done, scr_en, coset_en, scr_seq, hold, clr_a, clr_b;
  logic tx_act, tx_start, rxen_a, rxen_b, flag_a, flag_b, irq;
  logic [7:0] label;
  logic [63:0] data64, expd;
  logic [7:0] lbl_v [4] = '{8'h00, 8'ha5, 8'h5a, 8'hff};
  logic [7:0] cfg [3] = '{8'h10, 8'h08, 8'h18};
  int error_cnt = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  link_control_and_ecc_tx_buffer #(.NUM_MSG_BYTES(8)) i_dut (
    .clk(clk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .port_a_signal_loss(loss_a),
    .port_b_signal_loss(loss_b), .port_a_remote_lock(lock_a), .port_b_remote_lock(lock_b),
    .switch_finished(sw_fin), .port_a_rx_buffer_full(full_a), .port_b_rx_buffer_full(full_b),
    .port_a_signal_select(sel_a), .port_b_signal_select(sel_b),
    .port_a_msg_ack_signal_a(ack_aa), .port_a_msg_ack_signal_b(ack_ab),
    .port_b_msg_ack_signal_a(ack_ba), .port_b_msg_ack_signal_b(ack_bb),
    .active_port_select(act_sel), .port_switch_done(sw_done), .scrambler_enable(scr_en),
    .coset_enable(coset_en), .send_scrambler_seq(scr_seq), .hold_traffic(hold),
    .link_label_byte(label), .port_a_remote_alarm_clear(clr_a),
    .port_b_remote_alarm_clear(clr_b), .msg_tx_active(tx_act), .msg_tx_start(tx_start),
    .msg_data_bytes(data64), .port_a_msg_rx_enable(rxen_a), .port_b_msg_rx_enable(rxen_b),
    .port_a_rx_buffer_flag(flag_a), .port_b_rx_buffer_flag(flag_b), .irq(irq));

  far_end_model i_far (
    .clk(clk), .resetn(resetn), .msg_tx_start(tx_start), .port_a_delay(dly_a),
    .port_b_delay(dly_b), .port_a_use_b(far_a_b), .port_b_use_b(far_b_b),
    .port_a_msg_ack_signal_a(ack_aa), .port_a_msg_ack_signal_b(ack_ab),
    .port_b_msg_ack_signal_a(ack_ba), .port_b_msg_ack_signal_b(ack_bb));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // each access starts and ends on a falling edge, with one idle cycle after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    chk(cpu_rdata, e);
    @(negedge clk);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (tx_act !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk(tx_act, 1'b0);
  endtask

  task automatic pulse_switch;
    sw_fin = 1'b1;
    @(negedge clk);
    sw_fin = 1'b0;
  endtask

  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    // reset values, unmapped space
    rd(a_lsc, `LINK_STATUS_CONTROL_RST);
    rd(a_lbl, 8'h00);
    rd(a_alm, 8'h01);
    rd(a_ien, 8'h00);
    rd(a_snd, 8'h00);
    rd(8'h30, 8'h00);
    chk({scr_en, coset_en, rxen_a, rxen_b, flag_a, flag_b}, 6'b111010);
    // scrambler off, coset off, message channel off
    wr(a_lsc, 8'h40);
    rd(a_lsc, 8'h44);
    chk({scr_en, coset_en}, 2'b00);
    rd(a_alm, 8'h00);
    wr(a_snd, 8'h01);
    rd(a_snd, 8'h00);
    chk({flag_a, flag_b, rxen_a, rxen_b, tx_act}, 5'b00000);
    // port switch and remote lock handling
    lock_b = 1'b0;
    wr(a_lsc, 8'h02);
    rd(a_lsc, 8'h02);
    chk({act_sel, hold, scr_seq}, 3'b111);
    pulse_switch();
    rd(a_lsc, 8'h06);
    chk(sw_done, 1'b1);
    wr(a_lsc, 8'h82);
    chk({hold, scr_seq}, 2'b00);
    rd(a_lsc, 8'h86);
    lock_b = 1'b1;
    wr(a_lsc, 8'h03);
    chk({hold, scr_seq}, 2'b01);
    lock_a = 1'b0;
    wr(a_lsc, 8'h00);
    rd(a_lsc, 8'h00);
    chk({act_sel, hold}, 2'b01);
    lock_a = 1'b1;
    pulse_switch();
    // link label
    foreach (lbl_v[i])
    begin
      wr(a_lbl, lbl_v[i]);
      chk(label, lbl_v[i]);
      rd(a_lbl, lbl_v[i]);
    end
    // one message per port configuration; the disabled or first port acks early
    foreach (cfg[i])
    begin
      wr(a_lsc, cfg[i]);
      dly_a = (cfg[i] == 8'h10) ? 8'd30 : 8'd5;
      dly_b = (cfg[i] == 8'h10) ? 8'd5 : 8'd30;
      @(negedge clk);
      chk({flag_a, flag_b}, {cfg[i][4], cfg[i][3]});
      rd(a_alm, 8'h01);
      for (int k = 0; k < 8; k++)
      begin
        expd[(7-k)*8 +: 8] = 8'(16 * (i + 1) + k);
        wr(8'(`MSG_DATA_FIRST_OFS + k), expd[(7-k)*8 +: 8]);
      end
      chk(data64, expd);
      wr(a_ien, 8'h01);
      chk(irq, 1'b1);
      wr(a_snd, 8'h01);
      chk({tx_act, irq}, 2'b10);
      wr(`MSG_DATA_FIRST_OFS, 8'hee);
      chk(data64, expd);
      rd(a_alm, 8'h00);
      repeat (12) @(negedge clk);
      chk(tx_act, 1'b1);
      wait_idle();
      rd(a_alm, 8'h01);
      rd(a_alm, 8'h01);
      rd(a_snd, 8'h00);
    end
    // ack on the line not selected is refused; halt by clearing send
    wr(a_lsc, 8'h10);
    sel_a = 1'b1;
    dly_a = 8'd5;
    wr(a_snd, 8'h01);
    repeat (20) @(negedge clk);
    chk(tx_act, 1'b1);
    wr(a_snd, 8'h00);
    chk(tx_act, 1'b0);
    rd(a_alm, 8'h01);
    far_a_b = 1'b1;
    wr(a_snd, 8'h01);
    wait_idle();
    // local loss of signal
    wr(a_ien, 8'h08);
    loss_a = 1'b1;
    repeat (4) @(negedge clk);
    chk({clr_a, clr_b, irq}, 3'b101);
    rd(a_alm, 8'h0d);
    rd(a_alm, 8'h05);
    chk(irq, 1'b0);
    loss_a = 1'b0;
    repeat (4) @(negedge clk);
    chk({clr_a, irq}, 2'b01);
    rd(a_alm, 8'h0d);
    rd(a_alm, 8'h01);
    loss_b = 1'b1;
    repeat (4) @(negedge clk);
    chk({clr_a, clr_b}, 2'b01);
    rd(a_alm, 8'h0b);
    final_report();
  end
endmodule // link_control_and_ecc_tx_buffer_tb

`default_nettype wire
